// file: core/cac_pkg.sv
package cac_pkg;
  // Register offsets on the local register port (byte addresses)
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CORE   = 4'h4;
  // Status word field positions
  localparam int ST_DGC   = 8;
  localparam int ST_PRIH  = 7;
  localparam int ST_PRIL  = 5;
  localparam int ST_RPT   = 4;
  localparam int ST_N     = 3;
  localparam int ST_OVF   = 2;
  localparam int ST_Z     = 1;
  localparam int ST_C     = 0;
  // Core control field positions
  localparam int CC_UNS   = 12;
  localparam int CC_EXIT  = 11;
  localparam int CC_DLH   = 10;
  localparam int CC_DLL   = 8;
  localparam int CC_SATEA = 7;
  localparam int CC_SATEB = 6;
  localparam int CC_SDW   = 5;
  localparam int CC_ASM   = 4;
  localparam int CC_PRIX  = 3;
  localparam int CC_PSV   = 2;
  localparam int CC_ROUND = 1;
  localparam int CC_IF    = 0;
  // Reset values; only the store saturation enable comes up set
  localparam logic [15:0] ST_RESET = 16'h0000;
  localparam logic       SDW_RESET = 1'b1;
  // Digit carry is the carry into these bit positions
  localparam int DC_POS_BYTE = 4;
  localparam int DC_POS_WORD = 8;
  // One divider step per divisor bit
  localparam logic [4:0] DIV_STEPS = 5'h10;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_SHL, ALU_SHR, ALU_ASR
  } cac_op_e;

  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_FIX} cac_div_e;

  typedef struct packed {
    logic        go;
    cac_op_e     op;
    logic        byteMode;
    logic [15:0] a;
    logic [15:0] b;
  } cac_alu_req_s;

  typedef struct packed {
    logic        go;
    logic        dsp;
    logic        aSigned;
    logic        bSigned;
    logic [15:0] a;
    logic [15:0] b;
  } cac_mul_req_s;

  typedef struct packed {
    logic        go;
    logic        signedDiv;
    logic        wide;
    logic [31:0] dividend;
    logic [15:0] divisor;
  } cac_div_req_s;

  typedef struct packed {
    logic dspMulUnsigned;
    logic accASatEn;
    logic accBSatEn;
    logic storeSatEn;
    logic accSatMode;
    logic progSpaceVis;
    logic roundMode;
    logic intMulMode;
  } cac_cfg_s;

  typedef struct packed {
    logic [15:0] rdData;
    logic [2:0]  prioLevelLow;
    logic        prioLevelExt;
    logic        userIntDis;
    logic        negFlag;
    logic        signedOverflowFlag;
    logic        zeroFlag;
    logic        carryFlag;
    logic        digitCarryFlag;
    cac_cfg_s    cfg;
    logic        earlyLoopExit;
    logic [15:0] aluResult;
    logic        aluValid;
    logic [39:0] mulResult;
    logic        mulValid;
    cac_div_e    divState;
    logic [4:0]  divCnt;
    logic [15:0] divRem;
    logic [15:0] divLow;
    logic [15:0] divisor;
    logic        quoNeg;
    logic        remNeg;
    logic [15:0] workRegZero;
    logic [15:0] workRegOne;
    logic        divBusy;
    logic        divDone;
  } cac_state_s;
endpackage : cac_pkg

// file: core/cac_core.sv
// Summary of operation
// - Status bits 7:5 hold priority; with the extension bit they form four bits
// - User interrupts are off at priority 7 or with the extension bit set
// - Priority field ignores writes while nesting disable is high
// - Status bit 4 reads repeat-active; it cannot be written
// - Overflow flag marks a signed result whose sign went wrong
// - Zero flag set by a zero result, cleared by a non-zero one
// - Carry flag takes the carry out of the result's top bit
// - On subtraction carry and digit carry mean no borrow
// - 16-bit ALU adds, subtracts, shifts and does logic, byte or word
// - Control bit 12 picks unsigned DSP multiplies, else signed
// - Writing one to control bit 11 ends the DO loop; reads zero
// - Control bits 10:8 read the count of active nested DO loops
// - Control bits 7 and 6 enable saturation of accumulators A and B
// - Control bit 5 enables store saturation and resets to one
// - Control bit 4 picks super saturation, else normal saturation
// - Control bit 1 picks biased rounding, else convergent rounding
// - Control bit 0 picks integer DSP multiplies, else fractional
// - Divide leaves quotient in register zero, remainder in register one
// - Divider takes one cycle per divisor bit for both dividend sizes
// - Multiplier extends operands to 17 bits by zero or by sign
// - Multiplier gives a 33-bit result sign-extended to 40 bits
// - Digit carry is carry out of bit 3 for bytes, bit 7 for words
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cac_core (
  input  wire logic                  clk,             // CPU clock
  input  wire logic                  rst,             // Async reset
  input  wire logic [3:0]            regAddr,         // Register address
  input  wire logic [15:0]           regWrData,       // Write data
  input  wire logic                  regWr,           // Write strobe
  input  wire logic                  regRd,           // Read strobe
  output logic      [15:0]           regRdData,       // Read data
  input  wire logic                  nestingDisable,  // Nesting disable
  input  wire logic                  repeatActive,    // Repeat loop running
  input  wire logic [2:0]            loopNestDepth,   // Active DO loops
  input  wire cac_pkg::cac_alu_req_s aluReq,          // ALU request
  input  wire cac_pkg::cac_mul_req_s mulReq,          // Multiply request
  input  wire cac_pkg::cac_div_req_s divReq,          // Divide request
  output logic      [3:0]            prioLevel,       // CPU priority
  output logic                       userIntDisabled, // User irqs off
  output logic                       earlyLoopExit,   // End DO loop pulse
  output cac_pkg::cac_cfg_s          dspCfg,          // DSP engine config
  output logic      [15:0]           aluResult,       // ALU result
  output logic                       aluValid,        // Result pulse
  output logic      [39:0]           mulResult,       // Product, 40 bits
  output logic                       mulValid,        // Product pulse
  output logic      [15:0]           workRegZero,     // Quotient
  output logic      [15:0]           workRegOne,      // Remainder
  output logic                       divBusy,         // Divide running
  output logic                       divDone          // Divide end pulse
);
  cac_pkg::cac_state_s s_r;
  cac_pkg::cac_state_s s_nxt;

  logic [15:0] aOp;
  logic [15:0] bIn;
  logic [16:0] sum;
  logic [15:0] res;
  logic        msbIdx;
  logic        cOut;
  logic        digitCarry;
  logic        signedOvf;
  logic        arith;
  logic        shift;
  logic [16:0] mA;
  logic [16:0] mB;
  logic signed [33:0] prod;
  logic [32:0] p33;
  logic        mulUns;
  logic [31:0] dvdExt;
  logic [31:0] absDvd;
  logic [15:0] absDvs;
  logic [16:0] trial;
  logic        qBit;

  // Readback of a register; unmapped addresses read zero
  function automatic logic [15:0] readWord(
    input cac_pkg::cac_state_s s,
    input logic [3:0]          addr,
    input logic                rpt,
    input logic [2:0]          depth
  );
    logic [15:0] w;
    w = '0;
    if (addr == cac_pkg::OFS_STATUS) begin
      w[cac_pkg::ST_DGC] = s.digitCarryFlag;
      w[cac_pkg::ST_PRIH:cac_pkg::ST_PRIL] = s.prioLevelLow;
      w[cac_pkg::ST_RPT] = rpt;
      w[cac_pkg::ST_N] = s.negFlag;
      w[cac_pkg::ST_OVF] = s.signedOverflowFlag;
      w[cac_pkg::ST_Z] = s.zeroFlag;
      w[cac_pkg::ST_C] = s.carryFlag;
    end else if (addr == cac_pkg::OFS_CORE) begin
      w[cac_pkg::CC_UNS] = s.cfg.dspMulUnsigned;
      w[cac_pkg::CC_DLH:cac_pkg::CC_DLL] = depth;
      w[cac_pkg::CC_SATEA] = s.cfg.accASatEn;
      w[cac_pkg::CC_SATEB] = s.cfg.accBSatEn;
      w[cac_pkg::CC_SDW] = s.cfg.storeSatEn;
      w[cac_pkg::CC_ASM] = s.cfg.accSatMode;
      w[cac_pkg::CC_PRIX] = s.prioLevelExt;
      w[cac_pkg::CC_PSV] = s.cfg.progSpaceVis;
      w[cac_pkg::CC_ROUND] = s.cfg.roundMode;
      w[cac_pkg::CC_IF] = s.cfg.intMulMode;
    end
    return w;
  endfunction : readWord

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.earlyLoopExit = 1'b0;
    s_nxt.aluValid = 1'b0;
    s_nxt.mulValid = 1'b0;
    s_nxt.divDone = 1'b0;
    s_nxt.rdData = '0;
    if (regRd) begin
      s_nxt.rdData = readWord(s_r, regAddr, repeatActive, loopNestDepth);
    end

    // Software writes; the ALU flag update below overrides the flags it sets
    if (regWr && regAddr == cac_pkg::OFS_STATUS) begin
      if (!nestingDisable) begin
        s_nxt.prioLevelLow = regWrData[cac_pkg::ST_PRIH:cac_pkg::ST_PRIL];
      end
      s_nxt.digitCarryFlag = regWrData[cac_pkg::ST_DGC];
      s_nxt.negFlag = regWrData[cac_pkg::ST_N];
      s_nxt.signedOverflowFlag = regWrData[cac_pkg::ST_OVF];
      s_nxt.zeroFlag = regWrData[cac_pkg::ST_Z];
      s_nxt.carryFlag = regWrData[cac_pkg::ST_C];
    end
    if (regWr && regAddr == cac_pkg::OFS_CORE) begin
      s_nxt.cfg.dspMulUnsigned = regWrData[cac_pkg::CC_UNS];
      s_nxt.earlyLoopExit = regWrData[cac_pkg::CC_EXIT];
      s_nxt.cfg.accASatEn = regWrData[cac_pkg::CC_SATEA];
      s_nxt.cfg.accBSatEn = regWrData[cac_pkg::CC_SATEB];
      s_nxt.cfg.storeSatEn = regWrData[cac_pkg::CC_SDW];
      s_nxt.cfg.accSatMode = regWrData[cac_pkg::CC_ASM];
      s_nxt.cfg.progSpaceVis = regWrData[cac_pkg::CC_PSV];
      s_nxt.cfg.roundMode = regWrData[cac_pkg::CC_ROUND];
      s_nxt.cfg.intMulMode = regWrData[cac_pkg::CC_IF];
      // Extension bit is clear-only from software
      if (!regWrData[cac_pkg::CC_PRIX]) begin
        s_nxt.prioLevelExt = 1'b0;
      end
    end

    // ALU: byte mode works on the low byte, upper byte of result is zero
    msbIdx = aluReq.byteMode;
    aOp = aluReq.byteMode ? {8'h00, aluReq.a[7:0]} : aluReq.a;
    bIn = aluReq.byteMode ? {8'h00, aluReq.b[7:0]} : aluReq.b;
    if (aluReq.op == cac_pkg::ALU_SUB) begin
      // Add the complement plus one; carry out then means no borrow
      bIn = aluReq.byteMode ? {8'h00, ~aluReq.b[7:0]} : ~aluReq.b;
    end
    sum = {1'b0, aOp} + {1'b0, bIn} + {16'h0000, aluReq.op == cac_pkg::ALU_SUB};
    res = '0;
    cOut = 1'b0;
    arith = 1'b0;
    shift = 1'b0;
    unique case (aluReq.op)
      cac_pkg::ALU_ADD, cac_pkg::ALU_SUB: begin
        res = sum[15:0];
        arith = 1'b1;
        cOut = msbIdx ? sum[8] : sum[16];
      end
      cac_pkg::ALU_AND: res = aOp & bIn;
      cac_pkg::ALU_OR:  res = aOp | bIn;
      cac_pkg::ALU_XOR: res = aOp ^ bIn;
      cac_pkg::ALU_SHL: begin
        res = {aOp[14:0], 1'b0};
        shift = 1'b1;
        cOut = msbIdx ? aOp[7] : aOp[15];
      end
      cac_pkg::ALU_SHR: begin
        res = {1'b0, aOp[15:1]};
        shift = 1'b1;
        cOut = aOp[0];
      end
      cac_pkg::ALU_ASR: begin
        res = {aOp[15], aOp[15:1]};
        if (msbIdx) begin
          res[7] = aOp[7];
        end
        shift = 1'b1;
        cOut = aOp[0];
      end
    endcase
    if (aluReq.byteMode) begin
      res[15:8] = 8'h00;
    end
    // Carry into bit 4 or 8 is the carry out of bit 3 or 7
    digitCarry = msbIdx ? (aOp[cac_pkg::DC_POS_BYTE] ^ bIn[cac_pkg::DC_POS_BYTE] ^
                      sum[cac_pkg::DC_POS_BYTE])
                   : (aOp[cac_pkg::DC_POS_WORD] ^ bIn[cac_pkg::DC_POS_WORD] ^
                      sum[cac_pkg::DC_POS_WORD]);
    signedOvf = msbIdx ? (aOp[7] == bIn[7]) && (sum[7] != aOp[7])
                   : (aOp[15] == bIn[15]) && (sum[15] != aOp[15]);
    if (aluReq.go) begin
      s_nxt.aluResult = res;
      s_nxt.aluValid = 1'b1;
      s_nxt.negFlag = msbIdx ? res[7] : res[15];
      s_nxt.zeroFlag = (res == 16'h0000);
      if (arith) begin
        s_nxt.carryFlag = cOut;
        s_nxt.digitCarryFlag = digitCarry;
        s_nxt.signedOverflowFlag = signedOvf;
      end else if (shift) begin
        s_nxt.carryFlag = cOut;
        s_nxt.signedOverflowFlag = 1'b0;
      end
    end

    // Shared multiplier; DSP requests take sign and scaling from the control bits
    mulUns = mulReq.dsp ? s_r.cfg.dspMulUnsigned : !mulReq.aSigned;
    mA = {!mulUns & mulReq.a[15], mulReq.a};
    mulUns = mulReq.dsp ? s_r.cfg.dspMulUnsigned : !mulReq.bSigned;
    mB = {!mulUns & mulReq.b[15], mulReq.b};
    prod = $signed(mA) * $signed(mB);
    if (mulReq.dsp && !s_r.cfg.intMulMode) begin
      p33 = {prod[31:0], 1'b0};
    end else begin
      p33 = prod[32:0];
    end
    if (mulReq.go) begin
      s_nxt.mulResult = {{7{p33[32]}}, p33};
      s_nxt.mulValid = 1'b1;
    end

    // Divider: restoring division on magnitudes, signs fixed at the end
    dvdExt = divReq.dividend;
    if (!divReq.wide) begin
      dvdExt[31:16] = divReq.signedDiv ? {16{divReq.dividend[15]}} : 16'h0000;
    end
    absDvd = (divReq.signedDiv && dvdExt[31]) ? -dvdExt : dvdExt;
    absDvs = (divReq.signedDiv && divReq.divisor[15]) ? -divReq.divisor
                                                      : divReq.divisor;
    trial = {s_r.divRem, s_r.divLow[15]};
    qBit = (trial >= {1'b0, s_r.divisor});
    unique case (s_r.divState)
      cac_pkg::DIV_IDLE: begin
        if (divReq.go) begin
          s_nxt.divState = cac_pkg::DIV_RUN;
          s_nxt.divCnt = '0;
          s_nxt.divRem = absDvd[31:16];
          s_nxt.divLow = absDvd[15:0];
          s_nxt.divisor = absDvs;
          s_nxt.quoNeg = divReq.signedDiv & (dvdExt[31] ^ divReq.divisor[15]);
          s_nxt.remNeg = divReq.signedDiv & dvdExt[31];
        end
      end
      cac_pkg::DIV_RUN: begin
        // One quotient bit per cycle, same count for both dividend sizes
        s_nxt.divRem = qBit ? 16'(trial - {1'b0, s_r.divisor}) : trial[15:0];
        s_nxt.divLow = {s_r.divLow[14:0], qBit};
        s_nxt.divCnt = s_r.divCnt + 5'h01;
        if (s_r.divCnt == cac_pkg::DIV_STEPS - 5'h01) begin
          s_nxt.divState = cac_pkg::DIV_FIX;
        end
      end
      cac_pkg::DIV_FIX: begin
        s_nxt.workRegZero = s_r.quoNeg ? -s_r.divLow : s_r.divLow;
        s_nxt.workRegOne = s_r.remNeg ? -s_r.divRem : s_r.divRem;
        s_nxt.divDone = 1'b1;
        s_nxt.divState = cac_pkg::DIV_IDLE;
      end
      default: s_nxt.divState = cac_pkg::DIV_IDLE;
    endcase
    s_nxt.divBusy = (s_nxt.divState != cac_pkg::DIV_IDLE);
    s_nxt.userIntDis = (&s_nxt.prioLevelLow) | s_nxt.prioLevelExt;
  end

  // State register; store saturation enable is the one bit set at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.cfg.storeSatEn <= cac_pkg::SDW_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign regRdData = s_r.rdData;
  assign prioLevel = {s_r.prioLevelExt, s_r.prioLevelLow};
  assign userIntDisabled = s_r.userIntDis;
  assign earlyLoopExit = s_r.earlyLoopExit;
  assign dspCfg = s_r.cfg;
  assign aluResult = s_r.aluResult;
  assign aluValid = s_r.aluValid;
  assign mulResult = s_r.mulResult;
  assign mulValid = s_r.mulValid;
  assign workRegZero = s_r.workRegZero;
  assign workRegOne = s_r.workRegOne;
  assign divBusy = s_r.divBusy;
  assign divDone = s_r.divDone;

  // Helpers seen only by the checks
  logic [16:0] chkSum;
  logic [31:0] chkUProd;
  assign chkSum = {1'b0, aluReq.a} + {1'b0, aluReq.b};
  assign chkUProd = {16'h0000, mulReq.a} * {16'h0000, mulReq.b};

  chk_int_disable: assert property (@(posedge clk) disable iff (rst)
    userIntDisabled == ((prioLevel[2:0] == 3'h7) || prioLevel[3]))
    else $error("user interrupt disable does not match priority");

  chk_prio_locked: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == cac_pkg::OFS_STATUS && nestingDisable
    |=> $stable(prioLevel[2:0]))
    else $error("priority field changed while nesting disabled");

  chk_rpt_readback: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == cac_pkg::OFS_STATUS
    |=> regRdData[cac_pkg::ST_RPT] == $past(repeatActive))
    else $error("repeat active bit reads wrong");

  chk_loop_exit: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == cac_pkg::OFS_CORE && regWrData[cac_pkg::CC_EXIT]
    |=> earlyLoopExit)
    else $error("loop exit pulse missing");

  chk_exit_reads: assert property (@(posedge clk) disable iff (rst)
    regRd ##1 1'b1 |-> !regRdData[cac_pkg::CC_EXIT])
    else $error("loop exit bit does not read zero");

  chk_add_carry: assert property (@(posedge clk) disable iff (rst)
    aluReq.go && aluReq.op == cac_pkg::ALU_ADD && !aluReq.byteMode
    |=> (regWr || regRd || 1'b1) && $past(chkSum[16]) == s_r.carryFlag)
    else $error("carry flag wrong after word add");

  chk_add_ovf: assert property (@(posedge clk) disable iff (rst)
    aluReq.go && aluReq.op == cac_pkg::ALU_ADD && !aluReq.byteMode
    |=> s_r.signedOverflowFlag == $past((aluReq.a[15] == aluReq.b[15]) &&
                            (chkSum[15] != aluReq.a[15])))
    else $error("overflow flag wrong after word add");

  chk_zero_neg: assert property (@(posedge clk) disable iff (rst)
    aluReq.go |=> aluValid && s_r.zeroFlag == (aluResult == 16'h0000) &&
                  s_r.negFlag == ($past(aluReq.byteMode) ? aluResult[7]
                                                          : aluResult[15]))
    else $error("zero or negative flag wrong");

  chk_mul_unsigned: assert property (@(posedge clk) disable iff (rst)
    mulReq.go && !mulReq.dsp && !mulReq.aSigned && !mulReq.bSigned
    |=> mulValid && mulResult == {8'h00, $past(chkUProd)})
    else $error("unsigned product wrong");

  chk_div_time: assert property (@(posedge clk) disable iff (rst)
    divReq.go && !divBusy |=> divBusy ##17 divDone && !divBusy)
    else $error("divide did not end in time");
endmodule : cac_core
`default_nettype wire

// file: test/cac_dec_model.sv
`timescale 1ns/1ps
`default_nettype none
module cac_dec_model (
  input  wire logic              clk,    // CPU clock
  output var cac_pkg::cac_alu_req_s aluReq, // ALU request
  output var cac_pkg::cac_mul_req_s mulReq, // Multiply request
  output var cac_pkg::cac_div_req_s divReq  // Divide request
);
  // Idle requests at time zero
  initial begin
    aluReq = '0;
    mulReq = '0;
    divReq = '0;
  end

  // Operands flip after the taking edge so a late sample shows up as garbage
  task automatic aluGo(input cac_pkg::cac_op_e op, input logic bm, input logic [15:0] a,
                       input logic [15:0] b);
    @(posedge clk);
    aluReq <= '{go: 1'b1, op: op, byteMode: bm, a: a, b: b};
    @(posedge clk);
    aluReq <= '{go: 1'b0, op: op, byteMode: bm, a: ~a, b: ~b};
  endtask : aluGo

  // One-cycle multiply request
  task automatic mulGo(input logic dsp, input logic sa, input logic sb, input logic [15:0] a,
                       input logic [15:0] b);
    @(posedge clk);
    mulReq <= '{go: 1'b1, dsp: dsp, aSigned: sa, bSigned: sb, a: a, b: b};
    @(posedge clk);
    mulReq <= '{go: 1'b0, dsp: dsp, aSigned: sa, bSigned: sb, a: ~a, b: ~b};
  endtask : mulGo

  // One-cycle divide request; the caller decides whether the divider is free
  task automatic divGo(input logic sd, input logic wd, input logic [31:0] n,
                       input logic [15:0] d);
    @(posedge clk);
    divReq <= '{go: 1'b1, signedDiv: sd, wide: wd, dividend: n, divisor: d};
    @(posedge clk);
    divReq <= '{go: 1'b0, signedDiv: sd, wide: wd, dividend: ~n, divisor: ~d};
  endtask : divGo
endmodule : cac_dec_model
`default_nettype wire

// file: test/test_cpu_alu_dsp_status_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_cpu_alu_dsp_status_control;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [3:0]            regAddr = 4'h0;
  logic [15:0]           regWrData = 16'h0000;
  logic                  regWr = 1'b0;
  logic                  regRd = 1'b0;
  logic [15:0]           regRdData;
  logic                  nestingDisable = 1'b0;
  logic                  repeatActive = 1'b0;
  logic [2:0]            loopNestDepth = 3'h5;
  cac_pkg::cac_alu_req_s aluReq;
  cac_pkg::cac_mul_req_s mulReq;
  cac_pkg::cac_div_req_s divReq;
  logic [3:0]            prioLevel;
  logic                  userIntDisabled;
  logic                  earlyLoopExit;
  cac_pkg::cac_cfg_s     dspCfg;
  logic [15:0]           aluResult;
  logic                  aluValid;
  logic [39:0]           mulResult;
  logic                  mulValid;
  logic [15:0]           workRegZero;
  logic [15:0]           workRegOne;
  logic                  divBusy;
  logic                  divDone;
  int                    num_errors = 0;
  int                    tests_run = 0;

  cac_dec_model u_part (.clk(clk), .aluReq(aluReq), .mulReq(mulReq), .divReq(divReq));

  cac_core u_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .nestingDisable(nestingDisable),
    .repeatActive(repeatActive), .loopNestDepth(loopNestDepth), .aluReq(aluReq),
    .mulReq(mulReq), .divReq(divReq), .prioLevel(prioLevel),
    .userIntDisabled(userIntDisabled), .earlyLoopExit(earlyLoopExit), .dspCfg(dspCfg),
    .aluResult(aluResult), .aluValid(aluValid), .mulResult(mulResult), .mulValid(mulValid),
    .workRegZero(workRegZero), .workRegOne(workRegOne), .divBusy(divBusy), .divDone(divDone)
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  // Write cycle; data flips afterwards so a late sample would be caught
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regWrData <= ~d;
    #1;
  endtask : wr

  // Read cycle; data must stand one cycle only, then return to zero
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                    input string nm);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(nm, e, regRdData & m)
    @(posedge clk);
    #1;
    `CHK("rdIdle", 16'h0000, regRdData)
  endtask : rd

  // Reset values, depth shown in core control, unmapped address
  task automatic tReset();
    rd(cac_pkg::OFS_STATUS, 16'hffff, 16'h0000, "statusReset");
    rd(cac_pkg::OFS_CORE, 16'hffff, 16'h0520, "coreReset");
    `CHK("cfgReset", 8'h10, dspCfg)
    `CHK("prioReset", 4'h0, prioLevel)
    rd(4'h8, 16'hffff, 16'h0000, "unmapped");
  endtask : tReset

  // Priority field, user interrupt disable, write lock, repeat bit
  task automatic tPrio();
    wr(cac_pkg::OFS_STATUS, 16'h00e0);
    `CHK("prio7", 4'h7, prioLevel)
    `CHK("uid7", 1'b1, userIntDisabled)
    wr(cac_pkg::OFS_STATUS, 16'h0040);
    `CHK("prio2", 4'h2, prioLevel)
    `CHK("uid2", 1'b0, userIntDisabled)
    @(posedge clk) nestingDisable <= 1'b1;
    wr(cac_pkg::OFS_STATUS, 16'h00a0);
    rd(cac_pkg::OFS_STATUS, 16'h00e0, 16'h0040, "prioLocked");
    @(posedge clk) nestingDisable <= 1'b0;
    wr(cac_pkg::OFS_STATUS, 16'h0010);
    rd(cac_pkg::OFS_STATUS, 16'h0010, 16'h0000, "rptWrite");
    @(posedge clk) repeatActive <= 1'b1;
    rd(cac_pkg::OFS_STATUS, 16'h0010, 16'h0010, "rptShown");
    @(posedge clk) repeatActive <= 1'b0;
  endtask : tPrio

  // Core control fields, early exit pulse, read-only depth
  task automatic tCore();
    wr(cac_pkg::OFS_CORE, 16'h18ff);
    `CHK("exitPulse", 1'b1, earlyLoopExit)
    `CHK("cfgAll", 8'hff, dspCfg)
    `CHK("extClearOnly", 4'h0, prioLevel)
    @(posedge clk);
    #1;
    `CHK("exitEnd", 1'b0, earlyLoopExit)
    rd(cac_pkg::OFS_CORE, 16'hffff, 16'h15f7, "coreRead");
    @(posedge clk) loopNestDepth <= 3'h7;
    wr(cac_pkg::OFS_CORE, 16'h0000);
    `CHK("exitZero", 1'b0, earlyLoopExit)
    `CHK("cfgNone", 8'h00, dspCfg)
    rd(cac_pkg::OFS_CORE, 16'hffff, 16'h0700, "depth7");
  endtask : tCore

  // One ALU operation, its pulse and the flags seen in the status word
  task automatic aluChk(input cac_pkg::cac_op_e op, input logic bm, input logic [15:0] a,
                        input logic [15:0] b, input logic [15:0] r, input logic [15:0] f);
    u_part.aluGo(op, bm, a, b);
    #1;
    `CHK("aluValid", 1'b1, aluValid)
    `CHK("aluResult", r, aluResult)
    @(posedge clk);
    #1;
    `CHK("aluPulse", 1'b0, aluValid)
    rd(cac_pkg::OFS_STATUS, 16'h010f, f, "aluFlags");
  endtask : aluChk

  // Every operation at least once; flags not touched by an operation carry over
  task automatic tAlu();
    aluChk(cac_pkg::ALU_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 16'h010c);
    aluChk(cac_pkg::ALU_SUB, 1'b0, 16'h0005, 16'h0005, 16'h0000, 16'h0103);
    aluChk(cac_pkg::ALU_SUB, 1'b0, 16'h0000, 16'h0001, 16'hffff, 16'h0008);
    aluChk(cac_pkg::ALU_ADD, 1'b1, 16'h12ff, 16'h3401, 16'h0000, 16'h0103);
    aluChk(cac_pkg::ALU_AND, 1'b0, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'h0101);
    aluChk(cac_pkg::ALU_OR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 16'h0109);
    aluChk(cac_pkg::ALU_XOR, 1'b0, 16'h1234, 16'h1234, 16'h0000, 16'h0103);
    aluChk(cac_pkg::ALU_SHL, 1'b0, 16'h8001, 16'h0001, 16'h0002, 16'h0101);
    aluChk(cac_pkg::ALU_SHR, 1'b0, 16'h0002, 16'h0001, 16'h0001, 16'h0100);
    aluChk(cac_pkg::ALU_ASR, 1'b0, 16'h8001, 16'h0001, 16'hc000, 16'h0109);
    aluChk(cac_pkg::ALU_SUB, 1'b1, 16'hff10, 16'h0011, 16'h00ff, 16'h0008);
  endtask : tAlu

  // One multiply and its one-cycle pulse
  task automatic mulChk(input logic dsp, input logic sa, input logic sb, input logic [15:0] a,
                        input logic [15:0] b, input logic [39:0] p);
    u_part.mulGo(dsp, sa, sb, a, b);
    #1;
    `CHK("mulValid", 1'b1, mulValid)
    `CHK("mulResult", p, mulResult)
    @(posedge clk);
    #1;
    `CHK("mulPulse", 1'b0, mulValid)
  endtask : mulChk

  // Operand extension per signedness, DSP sign and scaling from core control
  task automatic tMul();
    mulChk(1'b0, 1'b1, 1'b1, 16'hffff, 16'h0002, 40'hfffffffffe);
    mulChk(1'b0, 1'b0, 1'b0, 16'hffff, 16'h0002, 40'h000001fffe);
    mulChk(1'b0, 1'b0, 1'b1, 16'hffff, 16'hffff, 40'hffffff0001);
    wr(cac_pkg::OFS_CORE, 16'h1001);
    mulChk(1'b1, 1'b1, 1'b1, 16'h8000, 16'h8000, 40'h0040000000);
    wr(cac_pkg::OFS_CORE, 16'h1000);
    mulChk(1'b1, 1'b1, 1'b1, 16'hffff, 16'h0002, 40'h000003fffc);
    wr(cac_pkg::OFS_CORE, 16'h0000);
    mulChk(1'b1, 1'b0, 1'b0, 16'h8000, 16'h8000, 40'h0080000000);
  endtask : tMul

  // Divide timing and results; poke issues a request that must be ignored
  task automatic divChk(input logic sd, input logic wd, input logic [31:0] n,
                        input logic [15:0] d, input logic [15:0] q, input logic [15:0] r,
                        input logic poke);
    int cyc;
    cyc = 1;
    u_part.divGo(sd, wd, n, d);
    #1;
    `CHK("divBusy", 1'b1, divBusy)
    if (poke) begin
      u_part.divGo(1'b0, 1'b1, 32'h00000064, 16'h000a);
      #1;
      cyc = 3;
    end
    while (divDone !== 1'b1 && cyc < 40) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    `CHK("divCycles", 32'd18, cyc)
    `CHK("quotient", q, workRegZero)
    `CHK("remainder", r, workRegOne)
    `CHK("divIdle", 1'b0, divBusy)
  endtask : divChk

  // Wide unsigned and narrow signed take the same time
  task automatic tDiv();
    divChk(1'b0, 1'b1, 32'h000186a0, 16'h0007, 16'h37cd, 16'h0005, 1'b0);
    divChk(1'b1, 1'b0, 32'h0000fff9, 16'h0002, 16'hfffd, 16'hffff, 1'b1);
    divChk(1'b1, 1'b1, 32'hfffe7960, 16'hfff9, 16'h37cd, 16'hfffb, 1'b0);
  endtask : tDiv

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tPrio();
    tCore();
    tAlu();
    tMul();
    tDiv();
    results();
  end

  // Watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : test_cpu_alu_dsp_status_control
`default_nettype wire
